// file: tb/io_stream_clump_vc_classifier_test.sv
// bench: host bridge and chain node joined over the link
`timescale 1ns/1ps
`default_nettype none
module io_stream_clump_vc_classifier_test;
	import ncv_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, clumpMask, nodeSupportOr = 32'h0000000C;
	logic allNodesFull = 1'b1, reqValid = 1'b0, reqReady, reqIsoc = 1'b0, cplValid, got;
	logic [2:0] delivValid, delivReady = 3'h0, rspSetField = 3'h0;
	cls_s [2:0] delivPkt;
	cls_s pkt;
	logic rspValid = 1'b0, rspReady, rspIsoc = 1'b0, rspBridge = 1'b0;
	logic [5:0] rspCmd = 6'h30, reqCmd = 6'h00;
	logic [4:0] rspNodeId = 5'h00, rspRequesterId = 5'h00, rspTag = 5'h00, upStream;
	logic [1:0] rspError = 2'h0, cplError;
	logic [3:0] reqSeq = 4'h0;
	logic [3:0] seqs [8] = '{4'h0, 4'hD, 4'hE, 4'hF, 4'hC, 4'h8, 4'hA, 4'h0};
	channel_set_e sets [8] = '{NCV_SET_ALT, NCV_SET_NONFC, NCV_SET_STREAM, NCV_SET_STREAM,
		NCV_SET_CCNUMA, NCV_SET_RSV, NCV_SET_IMPL, NCV_SET_BASE};
	int miscompares = 0;
	int checks = 0;
	ncv_link_if link ();
	// -----------------------------
	// both ends and the checker
	// -----------------------------
	ncv_host_bridge i_ncv_host_bridge (.ref_clk(ref_clk), .rst(rst), .link(link),
		.nodeSupportOr(nodeSupportOr), .allNodesFull(allNodesFull), .clumpMask(clumpMask),
		.reqValid(reqValid), .reqReady(reqReady), .reqCmd(reqCmd), .reqIsoc(reqIsoc),
		.reqSeq(reqSeq), .cplValid(cplValid), .cplError(cplError));
	ncv_chain_node #(.CLUMP_SUPPORT(32'h00000007)) i_ncv_chain_node (.ref_clk(ref_clk),
		.rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link),
		.delivValid(delivValid), .delivReady(delivReady), .delivPkt(delivPkt),
		.rspValid(rspValid), .rspReady(rspReady), .rspCmd(rspCmd), .rspNodeId(rspNodeId),
		.rspRequesterId(rspRequesterId), .rspTag(rspTag), .rspError(rspError),
		.rspIsoc(rspIsoc), .rspBridge(rspBridge), .rspSetField(rspSetField),
		.upStream(upStream));
	ncv_link_chk i_ncv_link_chk (.ref_clk(ref_clk), .rst(rst), .dnValid(link.dnValid),
		.dnReady(link.dnReady), .dnHdr(link.dnHdr), .upValid(link.upValid),
		.upReady(link.upReady), .upHdr(link.upHdr));
	// 200 MHz clock
	always #2.5 ref_clk = ~ref_clk;
	// -----------------------------
	// tasks
	// -----------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checks++;
		if (seen !== want) begin
			miscompares++;
			$display("BAD at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// bounded wait on one handshake, sampled at edges
	task automatic await(input int w);
		logic hit;
		for (int n = 0; n < 40; n++) begin
			@(posedge ref_clk);
			case (w)
				0: hit = reqReady;
				1: hit = rspReady;
				2: hit = link.upValid;
				3: hit = cplValid;
				default: hit = pready;
			endcase
			if (hit === 1'b1) return;
		end
		miscompares++;
		stop_test();
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		await(4);
		rd = prdata;
		check(pslverr, e);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic send(input logic [5:0] c, input logic i, input logic [3:0] s);
		reqValid <= 1'b1;
		reqCmd <= c;
		reqIsoc <= i;
		reqSeq <= s;
		await(0);
		reqValid <= 1'b0;
		@(posedge ref_clk);
	endtask
	// take one classified packet of class k, or time out as rejected
	task automatic take(input int k, output cls_s p, output logic g);
		for (int n = 0; n < 20 && delivValid[k] !== 1'b1; n++) begin
			@(posedge ref_clk);
		end
		g = delivValid[k];
		p = delivPkt[k];
		if (g === 1'b1) begin
			delivReady[k] <= 1'b1;
			@(posedge ref_clk);
			delivReady[k] <= 1'b0;
		end
	endtask
	// read request down, response back up from node identifier nd
	task automatic round(input logic [4:0] nd, input logic [4:0] want);
		cls_s p;
		logic g;
		send(6'h14, 1'b0, 4'h0);
		take(1, p, g);
		check(p.hdr[12:8], 5'h00);
		rspNodeId <= nd;
		rspRequesterId <= p.hdr[12:8];
		rspTag <= p.hdr[20:16];
		rspIsoc <= 1'b1;
		rspError <= 2'h2;
		rspValid <= 1'b1;
		await(1);
		rspValid <= 1'b0;
		await(2);
		check(link.upHdr[7], 1'b1);
		check(link.upHdr[31:30], p.hdr[9:8]);
		check(upStream, want);
		await(3);
		check(cplError, 2'h2);
	endtask
	// -----------------------------
	// sequence
	// -----------------------------
	initial begin
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		check(clumpMask, 32'h0000000E);
		allNodesFull <= 1'b0;
		repeat (2) @(posedge ref_clk);
		check(clumpMask, 32'h0000000C);
		nodeSupportOr <= 32'h0;
		apb(1'b0, 8'h00, 32'h0, 1'b0);
		check(rd, 32'h00000006);
		apb(1'b1, 8'h04, 32'hFFFFFFFF, 1'b0);
		apb(1'b0, 8'h04, 32'h0, 1'b0);
		check(rd, 32'hFFFFFFFE);
		apb(1'b1, 8'h04, 32'h0, 1'b0);
		apb(1'b1, 8'h08, 32'h1, 1'b0);
		apb(1'b0, 8'h08, 32'h0, 1'b0);
		check(rd, 32'h00000001);
		apb(1'b0, 8'h0C, 32'h0, 1'b0);
		check(rd, 32'h00061007);
		apb(1'b0, 8'h20, 32'h0, 1'b1);
		check(rd, 32'h0);
		// posted writes through every sequence group kind
		for (int i = 0; i < 8; i++) begin
			send({4'hA, i < 7, 1'b0}, i < 7, seqs[i]);
			take(0, pkt, got);
			check(got, i < 4 || i == 7);
			if (got === 1'b1) begin
				check(pkt.channel_set, sets[i]);
				check(pkt.stream, 5'h00);
				check(pkt.streamVc, sets[i] == NCV_SET_STREAM ? {seqs[i][0], 3'h0} : 4'h0);
				check(pkt.setNumber, i == 1 ? 3'h1 : (i == 2 || i == 3) ? 3'h2 : 3'h0);
			end
		end
		apb(1'b0, 8'h10, 32'h0, 1'b0);
		check(rd, 32'h00000003);
		// isoc flow control overrides the sequence group map
		apb(1'b1, 8'h08, 32'h2, 1'b0);
		send(6'h2A, 1'b1, 4'h0);
		take(0, pkt, got);
		check(pkt.channel_set, NCV_SET_ISOC);
		apb(1'b1, 8'h08, 32'h0, 1'b0);
		send(6'h3C, 1'b0, 4'h0);
		take(1, pkt, got);
		check(got, 1'b1);
		check(pkt.allStreams, 1'b1);
		send(6'h02, 1'b1, 4'h0);
		take(1, pkt, got);
		check(got, 1'b1);
		check(pkt.hdr[21], 1'b1);
		round(5'h03, 5'h03);
		apb(1'b1, 8'h04, 32'h00000010, 1'b0);
		round(5'h04, 5'h03);
		stop_test();
	end
endmodule
`default_nettype wire

// file: tb/ncv_link_chk.sv
// checker on the link between host bridge and chain node
`timescale 1ns/1ps
`default_nettype none
module ncv_link_chk (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// link signals
	input wire logic dnValid,
	input wire logic dnReady,
	input wire logic [31:0] dnHdr,
	input wire logic upValid,
	input wire logic upReady,
	input wire logic [31:0] upHdr
);
	import ncv_pkg::*;
	logic [127:0] busy;
	logic [7:0] open;
	logic np;
	logic rsp;
	// -----------------------------
	// outstanding nonposted tracking
	// -----------------------------
	// reads and flushes open a tag, responses close it
	assign np = dnValid && dnReady && (dnHdr[5:4] == 2'h1 || dnHdr[5:0] == 6'h02);
	assign rsp = upValid && upReady;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			busy <= '0;
			open <= 8'h00;
		end else begin
			if (np) begin
				busy[{dnHdr[9:8], dnHdr[20:16]}] <= 1'b1;
			end
			if (rsp) begin
				busy[{upHdr[31:30], upHdr[20:16]}] <= 1'b0;
			end
			open <= open + 8'(np) - 8'(rsp);
		end
	end
	// -----------------------------
	// assertions
	// -----------------------------
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	host_ids_a: assert property (dnValid |-> dnHdr[12:8] < 5'h04)
		else $error("host request identifier above 3");
	open_cap_a: assert property (open <= 8'h80)
		else $error("more than 128 requests outstanding");
	dn_hold_a: assert property (dnValid && !dnReady |=> dnValid && $stable(dnHdr))
		else $error("stalled request changed");
	quiet_reset_a: assert property ($fell(rst) |-> !dnValid && !upValid)
		else $error("traffic right after reset");
	tag_unique_a: assert property (np |-> !busy[{dnHdr[9:8], dnHdr[20:16]}])
		else $error("tag reused while outstanding");
	rsp_paired_a: assert property (rsp && !upHdr[14] |-> busy[{upHdr[31:30], upHdr[20:16]}])
		else $error("response pairs no open request");
	up_nonfc_a: assert property (upValid && upHdr[7] |-> !(upHdr[28:26] inside {3'h1, 3'h2}))
		else $error("response in posted-only set");
	dn_stream_a: assert property (dnValid && dnHdr[1] && isSized(dnHdr)
		&& hdrSeq(dnHdr) >= 4'hD |-> isPostedWrite(dnHdr))
		else $error("non-posted request in posted-only set");
	// main scenarios reached
	np_c: cover property (np);
	isoc_rsp_c: cover property (rsp && upHdr[7]);
	stall_c: cover property (dnValid && !dnReady);
endmodule
`default_nettype wire

// file: verilog/ncv_chain_node.sv
// chain node end: stream clumping and channel set classification
`timescale 1ns/1ps
`default_nettype none
`include "ncv_consts.svh"
module ncv_chain_node #(
	parameter logic [31:0] CLUMP_SUPPORT = 32'h00000000,
	parameter logic FULL_CLUMP = 1'b1,
	parameter logic PASSIVE_CLUMP = 1'b1,
	parameter logic [7:0] SET_SUPPORT = 8'h07,
	parameter logic [4:0] STREAM_SUPPORT = 5'h10
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// apb register port
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// link side
	ncv_link_if.node link,
	// classified downstream packets, one slot per class
	output logic [2:0] delivValid,
	input wire logic [2:0] delivReady,
	output ncv_pkg::cls_s [2:0] delivPkt,
	// upstream responses from the node core
	input wire logic rspValid,
	output logic rspReady,
	input wire logic [5:0] rspCmd,
	input wire logic [4:0] rspNodeId,
	input wire logic [4:0] rspRequesterId,
	input wire logic [4:0] rspTag,
	input wire logic [1:0] rspError,
	input wire logic rspIsoc,
	input wire logic rspBridge,
	input wire logic [2:0] rspSetField,
	output logic [4:0] upStream
);
	import ncv_pkg::*;

	//--------------------------------------------------------------
	// registers
	//--------------------------------------------------------------
	logic [31:0] clumpEnable, next_rdata;
	logic reorderDisable, isocFcEnable, regAccess, next_err;
	logic [15:0] rejectCount;

	// access phase answered after one wait cycle
	assign regAccess = psel && penable && pready;

	// read mux and unmapped decode
	always_comb begin
		next_rdata = 32'h00000000;
		next_err = 1'b0;
		unique case (paddr)
			`NCV_REG_CLUMP_SUPPORT: next_rdata = FULL_CLUMP ? {CLUMP_SUPPORT[31:1], 1'b0} : 32'h0;
			`NCV_REG_CLUMP_ENABLE: next_rdata = clumpEnable;
			`NCV_REG_CONTROL: next_rdata = {30'h0, isocFcEnable, reorderDisable};
			`NCV_REG_CAPS: next_rdata = {13'h0, FULL_CLUMP, PASSIVE_CLUMP, 4'h0, STREAM_SUPPORT,
				SET_SUPPORT};
			`NCV_REG_REJECTS: next_rdata = {16'h0, rejectCount};
			default: next_err = 1'b1;
		endcase
	end

	// apb answer timing
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && penable && !pready;
			prdata <= next_rdata;
			pslverr <= next_err;
		end
	end

	// configuration writes
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			clumpEnable <= `NCV_RESET_CLUMP;
			reorderDisable <= 1'b0;
			isocFcEnable <= 1'b0;
		end else if (regAccess && pwrite) begin
			if (paddr == `NCV_REG_CLUMP_ENABLE && FULL_CLUMP) begin
				clumpEnable <= {pwdata[31:1], 1'b0};
			end
			if (paddr == `NCV_REG_CONTROL) begin
				reorderDisable <= pwdata[`NCV_CTRL_REORDER_DIS] & PASSIVE_CLUMP;
				isocFcEnable <= pwdata[`NCV_CTRL_ISOC_FC_EN];
			end
		end
	end

	//--------------------------------------------------------------
	// downstream classification
	//--------------------------------------------------------------
	logic [31:0] dh;
	logic dIsRsp, dIsoc, dFence, dAccept, dClsFree;
	logic [3:0] dSeq, dStreamVc;
	logic [2:0] dSetNum, slotFull;
	channel_set_e dSet;
	class_e dClass;

	assign dh = link.dnHdr;
	assign dIsRsp = isResponse(dh);
	assign dFence = hdrCmd(dh) == `NCV_CMD_FENCE;
	assign dSeq = hdrSeq(dh);
	assign dStreamVc = {dSeq[0], dh[18:16]};

	// isoc flag position per packet family
	assign dIsoc = dIsRsp ? dh[`NCV_RSP_ISOC_BIT] :
		(dFence || hdrCmd(dh) == `NCV_CMD_FLUSH) ? dh[`NCV_FLUSH_ISOC_BIT] :
		isSized(dh) ? dh[`NCV_CMD_ISOC_BIT] : 1'b0;

	// channel set from isoc flag and sequence or response set field
	always_comb begin
		dSetNum = 3'h0;
		if (!dIsoc) begin
			dSet = NCV_SET_BASE;
		end else if (isocFcEnable) begin
			dSet = NCV_SET_ISOC;
		end else if (dIsRsp) begin
			dSetNum = dh[28:26];
			unique case (dh[28:26])
				3'h0: dSet = NCV_SET_ALT;
				3'h1: dSet = NCV_SET_NONFC;
				3'h2: dSet = NCV_SET_STREAM;
				3'h4: dSet = NCV_SET_CCNUMA;
				3'h6, 3'h7: dSet = NCV_SET_IMPL;
				default: dSet = NCV_SET_RSV;
			endcase
		end else if (!dSeq[3]) begin
			dSet = NCV_SET_ALT;
		end else if (dSeq == `NCV_SEQ_NONFC) begin
			dSet = NCV_SET_NONFC;
			dSetNum = 3'h1;
		end else if (dSeq[3:1] == 3'h7) begin
			dSet = NCV_SET_STREAM;
			dSetNum = 3'h2;
		end else if (dSeq == `NCV_SEQ_CCNUMA) begin
			dSet = NCV_SET_CCNUMA;
			dSetNum = 3'h4;
		end else if (dSeq[3:1] == 3'h5) begin
			dSet = NCV_SET_IMPL;
			dSetNum = {2'h3, dSeq[0]};
		end else begin
			dSet = NCV_SET_RSV;
			dSetNum = {dSeq[0], !dSeq[0], 1'b1}; // group 8 is set 3, group 9 is set 5
		end
	end

	// class and acceptance checks
	always_comb begin
		if (dIsRsp) begin
			dClass = NCV_CLS_RESPONSE;
		end else if (isPostedWrite(dh)) begin
			dClass = NCV_CLS_POSTED;
		end else begin
			dClass = NCV_CLS_NONPOSTED;
		end
		// host id must be 0, or clumped with 0 when enabled
		dAccept = dIsRsp || clumpBase(dh[12:8], clumpEnable) == 5'h00;
		if (dSet inside {NCV_SET_ALT, NCV_SET_NONFC, NCV_SET_STREAM, NCV_SET_RSV,
			NCV_SET_CCNUMA, NCV_SET_IMPL} && !SET_SUPPORT[dSetNum]) begin
			dAccept = 1'b0;
		end
		if ((dSet == NCV_SET_NONFC || dSet == NCV_SET_STREAM) && !isPostedWrite(dh)) begin
			dAccept = 1'b0;
		end
		if (dSet == NCV_SET_STREAM && {1'b0, dStreamVc} >= STREAM_SUPPORT) begin
			dAccept = 1'b0;
		end
	end

	// a blocked class stalls the whole link while a packet of its own class is next
	assign dClsFree = !slotFull[dClass] || delivReady[dClass];
	assign link.dnReady = dClsFree;

	// one dedicated slot per channel class
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			slotFull <= 3'h0;
			delivPkt <= '0;
		end else begin
			for (int c = 0; c < 3; c++) begin
				if (delivReady[c]) begin
					slotFull[c] <= 1'b0;
				end
			end
			if (link.dnValid && dClsFree && dAccept) begin
				slotFull[dClass] <= 1'b1;
				delivPkt[dClass].hdr <= dh;
				delivPkt[dClass].stream <= 5'h00;
				delivPkt[dClass].allStreams <= dFence;
				delivPkt[dClass].channel_set <= dSet;
				delivPkt[dClass].setNumber <= dSetNum;
				delivPkt[dClass].streamVc <= dSet == NCV_SET_STREAM ? dStreamVc : 4'h0;
			end
		end
	end
	assign delivValid = slotFull;

	// count packets turned away
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rejectCount <= 16'h0000;
		end else if (link.dnValid && dClsFree && !dAccept) begin
			rejectCount <= rejectCount + 16'h0001;
		end
	end

	//--------------------------------------------------------------
	// upstream responses
	//--------------------------------------------------------------
	logic upFull;

	assign rspReady = !upFull || link.upReady;
	assign link.upValid = upFull;

	// build the response header, tag echoed from the request
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			upFull <= 1'b0;
			link.upHdr <= 32'h00000000;
			upStream <= 5'h00;
		end else begin
			if (link.upReady) begin
				upFull <= 1'b0;
			end
			if (rspValid && rspReady) begin
				upFull <= 1'b1;
				// tag comes from a request whose tag was unique per id
				link.upHdr <= {rspBridge ? 2'h0 : rspRequesterId[1:0], rspError[1],
					rspIsoc ? rspSetField : 3'h0, 2'h0, 2'h0, rspError[0], rspTag,
					1'b0, rspBridge, 1'b0, rspNodeId, rspIsoc, 1'b0, rspCmd};
				// passive mode orders all upstream together
				upStream <= reorderDisable ? 5'h00 : clumpBase(rspNodeId, clumpEnable);
			end
		end
	end
endmodule
`default_nettype wire

// file: verilog/ncv_consts.svh
// constants for the stream clumping and channel set classifier
`ifndef NCV_CONSTS_SVH
`define NCV_CONSTS_SVH
// register byte offsets on the node's apb port
`define NCV_REG_CLUMP_SUPPORT 8'h00
`define NCV_REG_CLUMP_ENABLE 8'h04
`define NCV_REG_CONTROL 8'h08
`define NCV_REG_CAPS 8'h0C
`define NCV_REG_REJECTS 8'h10
// control register bit positions
`define NCV_CTRL_REORDER_DIS 0
`define NCV_CTRL_ISOC_FC_EN 1
// command codes
`define NCV_CMD_RD_RESPONSE 6'h30
`define NCV_CMD_TGT_DONE 6'h33
`define NCV_CMD_FLUSH 6'h02
`define NCV_CMD_FENCE 6'h3C
// header fields: isoc positions per packet family
`define NCV_CMD_ISOC_BIT 1
`define NCV_FLUSH_ISOC_BIT 21
`define NCV_RSP_ISOC_BIT 7
// sequence group codes of the isochronous request map
`define NCV_SEQ_NONFC 4'hD
`define NCV_SEQ_CCNUMA 4'hC
// limits
`define NCV_TAGS_PER_ID 32
`define NCV_HOST_IDS 4
`define NCV_RESET_CLUMP 32'h00000000
`endif

// file: verilog/ncv_host_bridge.sv
// host bridge end: request issue, tag allocation and clump mask
`timescale 1ns/1ps
`default_nettype none
`include "ncv_consts.svh"
module ncv_host_bridge #(
	parameter logic [31:0] HOST_CLUMP_SUPPORT = 32'h0000000E
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// link side
	ncv_link_if.host link,
	// clump mask setup
	input wire logic [31:0] nodeSupportOr,
	input wire logic allNodesFull,
	output logic [31:0] clumpMask,
	// requests from the host domain
	input wire logic reqValid,
	output logic reqReady,
	input wire logic [5:0] reqCmd,
	input wire logic reqIsoc,
	input wire logic [3:0] reqSeq,
	// completions to the host domain
	output logic cplValid,
	output logic [1:0] cplError
);
	import ncv_pkg::*;

	logic [127:0] busy;
	logic [6:0] freeSlot;
	logic freeFound;
	logic [2:0] hostIds;
	logic [31:0] next_hdr;

	// host clump limited to ids 0..3, mask ORed only with all full
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			clumpMask <= `NCV_RESET_CLUMP;
		end else begin
			clumpMask <= {nodeSupportOr[31:1] | (allNodesFull ?
				{28'h0, HOST_CLUMP_SUPPORT[3:1]} : 31'h0), 1'b0};
		end
	end

	// number of usable ids: those clumped with id 0
	always_comb begin
		hostIds = 3'h1;
		if (clumpMask[1]) begin
			hostIds = 3'h2;
			if (clumpMask[2]) begin
				hostIds = 3'h3;
				if (clumpMask[3]) begin
					hostIds = 3'(`NCV_HOST_IDS);
				end
			end
		end
	end

	// lowest free (id, tag) pair; each id owns 32 tags
	always_comb begin
		freeSlot = 7'h00;
		freeFound = 1'b0;
		for (int i = 127; i >= 0; i--) begin
			if (!busy[i] && i < int'(hostIds) * `NCV_TAGS_PER_ID) begin
				freeSlot = 7'(i);
				freeFound = 1'b1;
			end
		end
	end

	// request header with isoc placed per command family
	always_comb begin
		next_hdr = {8'h00, 3'h0, freeSlot[4:0], 1'b0, reqSeq[1:0], 3'h0, freeSlot[6:5],
			reqSeq[3:2], reqCmd};
		if (reqCmd == `NCV_CMD_FLUSH || reqCmd == `NCV_CMD_FENCE) begin
			next_hdr[`NCV_FLUSH_ISOC_BIT] = reqIsoc;
		end else begin
			next_hdr[`NCV_CMD_ISOC_BIT] = reqIsoc;
		end
	end

	assign reqReady = freeFound && (!link.dnValid || link.dnReady);
	assign link.upReady = 1'b1;

	// issue and track outstanding nonposted tags
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			link.dnValid <= 1'b0;
			link.dnHdr <= 32'h00000000;
			busy <= '0;
		end else begin
			if (link.dnReady) begin
				link.dnValid <= 1'b0;
			end
			if (link.upValid) begin
				busy[{link.upHdr[31:30], link.upHdr[20:16]}] <= 1'b0;
			end
			if (reqValid && reqReady) begin
				link.dnValid <= 1'b1;
				link.dnHdr <= next_hdr;
				if (!isPostedWrite(next_hdr) && reqCmd != `NCV_CMD_FENCE) begin
					busy[freeSlot] <= 1'b1;
				end
			end
		end
	end

	// completion out with no stream identity carried inward
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cplValid <= 1'b0;
			cplError <= 2'h0;
		end else begin
			cplValid <= link.upValid;
			cplError <= {link.upHdr[29], link.upHdr[21]};
		end
	end
endmodule
`default_nettype wire

// file: verilog/ncv_link_if.sv
// link between the host bridge end and the chain node end
`timescale 1ns/1ps
`default_nettype none
interface ncv_link_if;
	// downstream control packets, host to node
	logic dnValid;
	logic dnReady;
	logic [31:0] dnHdr;
	// upstream control packets, node to host
	logic upValid;
	logic upReady;
	logic [31:0] upHdr;

	modport host (output dnValid, output dnHdr, input dnReady,
		input upValid, input upHdr, output upReady);
	modport node (input dnValid, input dnHdr, output dnReady,
		output upValid, output upHdr, input upReady);
endinterface
`default_nettype wire

// file: verilog/ncv_pkg.sv
// types and header decoding shared by both ends
`default_nettype none
package ncv_pkg;
	typedef enum logic [2:0] {NCV_SET_BASE, NCV_SET_ISOC, NCV_SET_ALT, NCV_SET_NONFC,
		NCV_SET_STREAM, NCV_SET_RSV, NCV_SET_CCNUMA, NCV_SET_IMPL} channel_set_e;
	typedef enum logic [1:0] {NCV_CLS_POSTED, NCV_CLS_NONPOSTED, NCV_CLS_RESPONSE} class_e;
	typedef struct packed {
		logic [31:0] hdr;
		logic [4:0] stream;
		logic allStreams;
		channel_set_e channel_set;
		logic [2:0] setNumber;
		logic [3:0] streamVc;
	} cls_s;

	// header field extraction
	function automatic logic [5:0] hdrCmd(input logic [31:0] h);
		return h[5:0];
	endfunction
	function automatic logic [3:0] hdrSeq(input logic [31:0] h);
		return {h[7:6], h[14:13]};
	endfunction
	function automatic logic isResponse(input logic [31:0] h);
		return h[5:0] == 6'h30 || h[5:0] == 6'h33;
	endfunction
	function automatic logic isPostedWrite(input logic [31:0] h);
		return h[5:3] == 3'h5;
	endfunction
	function automatic logic isSized(input logic [31:0] h);
		return h[5:4] == 2'h1 || h[5:3] == 3'h5 || h[5:3] == 3'h1;
	endfunction

	// lowest identifier of the clump holding id (bit n set: n joins n-1)
	function automatic logic [4:0] clumpBase(input logic [4:0] id, input logic [31:0] mask);
		logic [4:0] b;
		b = id;
		for (int i = 0; i < 32; i++) begin
			if (b != 5'h00 && mask[b]) begin
				b = b - 5'h01;
			end
		end
		return b;
	endfunction
endpackage
`default_nettype wire
